/* verilog/apm_block.sv */
// apm_block: acpi fixed power-management event block with host and ec ports
// assumes: one clock, synchronous reset, both ports avalon-mm slaves
//
// Overview of operation
// - all sequential logic runs on the single block clock
// - system reset returns every register and all logic to defaults
// - host write to control 2 pulses the control-write interrupt to the ec
// - host write to enable 2 pulses the enable-write interrupt to the ec
// - host write to status 2 pulses the status-write interrupt to the ec
// - block enters a frozen low power state on controller request
// - status and control 2 hold power button, sleep, alarm, override, wake, sleep type, sleep enable and override enable bits
// - block drives a system control interrupt pin to the host
// - one sci output serves as both wake and runtime event
// - host writing one clears a status bit unless the ec writes one to it in the same cycle, zero leaves it
// - ec may read and write every status bit
// - enable bits are host writable and ec read-only
// - override enable sits at bit 1 of control 2
// - status and matching enable both set produce an sci event
// - status 2 at index 01h: wake 7, override 3, alarm 2, sleep 1, power 0
// - ec write of one sets a status bit, zero clears it
// - enable 2 at index 03h: alarm 2, sleep 1, power 0, reset zero
`default_nettype none

// ********************************************************************
// avalon slave front end, one wait state per access while run_in is high, waitrequest held while run_in is low
// ********************************************************************
module apm_av_slave (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  run_in,
	input  wire apm_pkg::apm_av_req_t  req_in,
	input  wire logic [apm_pkg::DW-1:0] rd_value_in,
	output var  apm_pkg::apm_av_rsp_t  rsp_out,
	output logic                       wr_fire_out,
	output logic [apm_pkg::IW-1:0]     idx_out,
	output logic                       busy_out
);
	import apm_pkg::*;

	logic          done_q;
	logic          done_d;
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] rdata_d;
	wire           req_act;
	wire           capture;

	assign req_act  = req_in.read | req_in.write;
	assign capture  = run_in & req_in.read & ~done_q;
	assign done_d   = req_act & ~done_q;
	assign rdata_d  = capture ? rd_value_in : rdata_q;
	assign busy_out = req_act;
	assign idx_out  = req_in.address[AW-1:IDX_LSB];
	assign wr_fire_out = run_in & req_in.write & done_q & req_in.byteenable[0];
	assign rsp_out.waitrequest = req_act & ~(done_q & run_in);
	assign rsp_out.readdata    = rdata_q;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			done_q  <= 1'b0;
			rdata_q <= '0;
		end
		else if (run_in)
		begin
			done_q  <= done_d;
			rdata_q <= rdata_d;
		end
	end
endmodule

// ********************************************************************
// top of the pm event block
// ********************************************************************
module apm_block (
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	input  wire logic                 ce_in,
	input  wire logic                 sleep_req_in,
	input  wire apm_pkg::apm_av_req_t host_req_in,
	output var  apm_pkg::apm_av_rsp_t host_rsp_out,
	input  wire apm_pkg::apm_av_req_t ec_req_in,
	output var  apm_pkg::apm_av_rsp_t ec_rsp_out,
	output logic                      sleep_ack_out,
	output logic                      sci_out_n,
	output logic                      control_write_irq_out,
	output logic                      enable_write_irq_out,
	output logic                      status_write_irq_out,
	output logic [2:0]                sleep_type_field_out,
	output logic                      sleep_enable_bit_out
);
	import apm_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	apm_pwr_t      pwr_q;
	apm_pwr_t      pwr_d;
	logic [BW-1:0] sts_q;
	logic [BW-1:0] sts_d;
	logic [BW-1:0] en_q;
	logic [BW-1:0] en_d;
	logic [BW-1:0] ctl1_q;
	logic [BW-1:0] ctl1_d;
	logic [BW-1:0] ctl2_q;
	logic [BW-1:0] ctl2_d;
	logic [BW-1:0] pm2c1_q;
	logic [BW-1:0] pm2c1_d;
	logic [BW-1:0] pm2c2_q;
	logic [BW-1:0] pm2c2_d;
	logic [BW-1:0] ecsts_q;
	logic [BW-1:0] ecsts_d;
	logic          sci_q;
	logic          sci_d;
	logic          ctl_irq_q;
	logic          en_irq_q;
	logic          sts_irq_q;
	wire           run;
	wire           host_fire;
	wire           ec_fire;
	wire           host_busy;
	wire           ec_busy;
	wire [IW-1:0]  host_idx;
	wire [IW-1:0]  ec_idx;
	wire [DW-1:0]  host_rd;
	wire [DW-1:0]  ec_rd;
	wire [BW-1:0]  host_wb;
	wire [BW-1:0]  ec_wb;
	wire           h_sts;
	wire           h_en;
	wire           h_ctl1;
	wire           h_ctl2;
	wire           h_pm2c1;
	wire           h_pm2c2;
	wire           e_sts;
	wire           e_ecsts;
	wire [BW-1:0]  host_clr;
	wire [BW-1:0]  ec_base;
	wire [BW-1:0]  ec_set;
	wire           evt_hit;
	wire           ovr_hit;

	// ****************************************************************
	// readback
	// ****************************************************************
	function automatic logic [BW-1:0] rd_mux(input logic [IW-1:0] idx,
		input logic [BW-1:0] s, input logic [BW-1:0] e,
		input logic [BW-1:0] c1, input logic [BW-1:0] c2,
		input logic [BW-1:0] p1, input logic [BW-1:0] p2,
		input logic [BW-1:0] x);
		logic [BW-1:0] r;
		r = REG_RST;
		case (idx)
			IDX_STS2:  r = s;
			IDX_EN2:   r = e;
			IDX_CTL1:  r = c1;
			IDX_CTL2:  r = c2;
			IDX_PM2C1: r = p1;
			IDX_PM2C2: r = p2;
			IDX_ECSTS: r = x;
			default:   r = REG_RST;
		endcase
		return r;
	endfunction

	assign host_rd = {PAD_ZERO, rd_mux(host_idx, sts_q, en_q, ctl1_q, ctl2_q,
		pm2c1_q, pm2c2_q, ecsts_q)};
	assign ec_rd   = {PAD_ZERO, rd_mux(ec_idx, sts_q, en_q, ctl1_q, ctl2_q,
		pm2c1_q, pm2c2_q, ecsts_q)};

	// ****************************************************************
	// bus ports
	// ****************************************************************
	apm_av_slave u_host (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.run_in      (run),
		.req_in      (host_req_in),
		.rd_value_in (host_rd),
		.rsp_out     (host_rsp_out),
		.wr_fire_out (host_fire),
		.idx_out     (host_idx),
		.busy_out    (host_busy)
	);

	apm_av_slave u_ec (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.run_in      (run),
		.req_in      (ec_req_in),
		.rd_value_in (ec_rd),
		.rsp_out     (ec_rsp_out),
		.wr_fire_out (ec_fire),
		.idx_out     (ec_idx),
		.busy_out    (ec_busy)
	);

	// ****************************************************************
	// low power state
	// ****************************************************************
	assign run = ce_in & (pwr_q == APM_ACTIVE);
	always_comb
	begin
		pwr_d = pwr_q;
		case (pwr_q)
			APM_ACTIVE:
				if (sleep_req_in & ~host_busy & ~ec_busy)
					pwr_d = APM_ASLEEP;
			APM_ASLEEP:
				if (~sleep_req_in)
					pwr_d = APM_ACTIVE;
			default:
				pwr_d = APM_ACTIVE;
		endcase
	end
	assign sleep_ack_out = (pwr_q == APM_ASLEEP);

	// ****************************************************************
	// write decode
	// ****************************************************************
	assign host_wb = host_req_in.writedata[BW-1:0];
	assign ec_wb   = ec_req_in.writedata[BW-1:0];
	assign h_sts   = host_fire & (host_idx == IDX_STS2);
	assign h_en    = host_fire & (host_idx == IDX_EN2);
	assign h_ctl1  = host_fire & (host_idx == IDX_CTL1);
	assign h_ctl2  = host_fire & (host_idx == IDX_CTL2);
	assign h_pm2c1 = host_fire & (host_idx == IDX_PM2C1);
	assign h_pm2c2 = host_fire & (host_idx == IDX_PM2C2);
	assign e_sts   = ec_fire & (ec_idx == IDX_STS2);
	assign e_ecsts = ec_fire & (ec_idx == IDX_ECSTS);

	// ****************************************************************
	// status bits
	// ****************************************************************
	assign host_clr = h_sts ? (host_wb & STS_MASK) : REG_RST;
	assign ec_base  = e_sts ? (ec_wb & STS_MASK) : sts_q;
	assign ec_set   = e_sts ? (ec_wb & STS_MASK) : REG_RST;
	assign sts_d    = ec_base & ~(host_clr & ~ec_set);

	// ****************************************************************
	// enable, control and ec status
	// ****************************************************************
	assign en_d    = h_en ? (host_wb & EN_MASK) : en_q;
	assign ctl1_d  = h_ctl1 ? host_wb : ctl1_q;
	assign ctl2_d  = h_ctl2 ? (host_wb & CTL2_MASK) : ctl2_q;
	assign pm2c1_d = h_pm2c1 ? host_wb : pm2c1_q;
	assign pm2c2_d = h_pm2c2 ? host_wb : pm2c2_q;
	assign ecsts_d = e_ecsts ? (ec_wb & ECSTS_MASK) : ecsts_q;

	// ****************************************************************
	// sci generation
	// ****************************************************************
	assign evt_hit = |(sts_q & en_q & EN_MASK);
	assign ovr_hit = sts_q[STS_OVR] & ctl2_q[CTL2_OVR_EN];
	assign sci_d   = evt_hit | ovr_hit | ecsts_q[ECSTS_SCI];
	assign sci_out_n = ~sci_q;

	assign sleep_type_field_out = ctl2_q[CTL2_TYP_HI:CTL2_TYP_LO];
	assign sleep_enable_bit_out = ctl2_q[CTL2_SLEEP_ENABLE_BIT];
	assign control_write_irq_out = ctl_irq_q;
	assign enable_write_irq_out  = en_irq_q;
	assign status_write_irq_out  = sts_irq_q;

	// ****************************************************************
	// state
	// ****************************************************************
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			pwr_q <= APM_ACTIVE;
		else if (ce_in)
			pwr_q <= pwr_d;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sts_q   <= REG_RST;
			en_q    <= REG_RST;
			ctl1_q  <= REG_RST;
			ctl2_q  <= REG_RST;
			pm2c1_q <= REG_RST;
			pm2c2_q <= REG_RST;
			ecsts_q <= REG_RST;
		end
		else if (run)
		begin
			sts_q   <= sts_d;
			en_q    <= en_d;
			ctl1_q  <= ctl1_d;
			ctl2_q  <= ctl2_d;
			pm2c1_q <= pm2c1_d;
			pm2c2_q <= pm2c2_d;
			ecsts_q <= ecsts_d;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sci_q     <= 1'b0;
			ctl_irq_q <= 1'b0;
			en_irq_q  <= 1'b0;
			sts_irq_q <= 1'b0;
		end
		else if (ce_in)
		begin
			sci_q     <= sci_d;
			ctl_irq_q <= h_ctl2;
			en_irq_q  <= h_en;
			sts_irq_q <= h_sts;
		end
	end
endmodule

`default_nettype wire

/* shared/apm_pkg.sv */
// apm_pkg: constants and carrier types of the pm event block
// assumes: 32-bit avalon-mm register ports, one byte of data per word
`default_nettype none

package apm_pkg;

	// ****************************************************************
	// bus geometry
	// ****************************************************************
	localparam int unsigned AW = 6;
	localparam int unsigned DW = 32;
	localparam int unsigned IW = 4;
	localparam int unsigned BW = 8;
	localparam int unsigned IDX_LSB = 2;

	// ****************************************************************
	// register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [IW-1:0] IDX_STS1  = 4'h0;
	localparam logic [IW-1:0] IDX_STS2  = 4'h1;
	localparam logic [IW-1:0] IDX_EN1   = 4'h2;
	localparam logic [IW-1:0] IDX_EN2   = 4'h3;
	localparam logic [IW-1:0] IDX_CTL1  = 4'h4;
	localparam logic [IW-1:0] IDX_CTL2  = 4'h5;
	localparam logic [IW-1:0] IDX_PM2C1 = 4'h6;
	localparam logic [IW-1:0] IDX_PM2C2 = 4'h7;
	localparam logic [IW-1:0] IDX_ECSTS = 4'h8;

	// ****************************************************************
	// field positions, masks and reset values
	// ****************************************************************
	localparam int unsigned STS_PWR   = 0;
	localparam int unsigned STS_SLEEP = 1;
	localparam int unsigned STS_ALARM = 2;
	localparam int unsigned STS_OVR   = 3;
	localparam int unsigned STS_WAKE  = 7;
	localparam logic [BW-1:0] STS_MASK  = 8'h8f;
	localparam logic [BW-1:0] EN_MASK   = 8'h07;
	localparam int unsigned CTL2_OVR_EN  = 1;
	localparam int unsigned CTL2_TYP_LO  = 2;
	localparam int unsigned CTL2_TYP_HI  = 4;
	localparam int unsigned CTL2_SLEEP_ENABLE_BIT  = 5;
	localparam logic [BW-1:0] CTL2_MASK = 8'h3e;
	localparam logic [BW-1:0] ECSTS_MASK = 8'h01;
	localparam int unsigned ECSTS_SCI  = 0;
	localparam logic [BW-1:0] REG_RST   = 8'h00;
	localparam logic [DW-BW-1:0] PAD_ZERO = 24'h000000;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef struct packed {
		logic          read;
		logic          write;
		logic [AW-1:0] address;
		logic [DW-1:0] writedata;
		logic [3:0]    byteenable;
	} apm_av_req_t;

	typedef struct packed {
		logic          waitrequest;
		logic [DW-1:0] readdata;
	} apm_av_rsp_t;

	typedef enum logic [1:0] {
		APM_ACTIVE = 2'b01,
		APM_ASLEEP = 2'b10
	} apm_pwr_t;

endpackage

`default_nettype wire

/* verif/apm_block_assertions.sv */
// apm_block_assertions: port checks of the pm event block
// assumes: bound onto apm_block, one clock, sync reset
`default_nettype none
// ****************
// checker
// ****************
module apm_block_assertions
	import apm_pkg::*;
(
	input wire logic                 clk_in,
	input wire logic                 rst_in,
	input wire logic                 ce_in,
	input wire logic                 sleep_req_in,
	input wire apm_pkg::apm_av_req_t host_req_in,
	input wire apm_pkg::apm_av_rsp_t host_rsp_out,
	input wire apm_pkg::apm_av_req_t ec_req_in,
	input wire logic                 sleep_ack_out,
	input wire logic                 control_write_irq_out,
	input wire logic                 enable_write_irq_out,
	input wire logic                 status_write_irq_out,
	input wire logic [2:0]           sleep_type_field_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	wire logic [IW-1:0] hix = host_req_in.address[AW-1:IDX_LSB];
	wire logic hacc = host_req_in.write && !host_rsp_out.waitrequest && host_req_in.byteenable[0];
	wire logic hctl = hacc && hix == IDX_CTL2;
	wire logic idle = !(host_req_in.read || host_req_in.write || ec_req_in.read || ec_req_in.write);
	property p_ctl; hctl |=> control_write_irq_out; endproperty
	a_ctl: assert property (p_ctl) else $error("no control irq");
	property p_en; hacc && hix == IDX_EN2 |=> enable_write_irq_out; endproperty
	a_en: assert property (p_en) else $error("no enable irq");
	property p_sts; hacc && hix == IDX_STS2 |=> status_write_irq_out; endproperty
	a_sts: assert property (p_sts) else $error("no status irq");
	property p_pulse; enable_write_irq_out && ce_in |=> !enable_write_irq_out; endproperty
	a_pulse: assert property (p_pulse) else $error("irq too long");
	property p_cause; $rose(control_write_irq_out) |-> $past(hctl); endproperty
	a_cause: assert property (p_cause) else $error("spurious control irq");
	property p_typ; $changed(sleep_type_field_out) |-> $past(hctl) || $past(hctl, 2) || $past(rst_in); endproperty
	a_typ: assert property (p_typ) else $error("sleep type moved");
	property p_slp; sleep_req_in && ce_in && idle |-> ##[1:2] sleep_ack_out; endproperty
	a_slp: assert property (p_slp) else $error("no sleep ack");
	property p_frz; sleep_ack_out && host_req_in.read |-> host_rsp_out.waitrequest; endproperty
	a_frz: assert property (p_frz) else $error("answered asleep");
endmodule

bind apm_block apm_block_assertions i_apm_block_assertions (
	.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .sleep_req_in(sleep_req_in),
	.host_req_in(host_req_in), .host_rsp_out(host_rsp_out), .ec_req_in(ec_req_in),
	.sleep_ack_out(sleep_ack_out), .control_write_irq_out(control_write_irq_out),
	.enable_write_irq_out(enable_write_irq_out), .status_write_irq_out(status_write_irq_out),
	.sleep_type_field_out(sleep_type_field_out)
);
`default_nettype wire

/* verif/apm_ec_model.sv */
// apm_ec_model: controller firmware driving the ec register port
// assumes: one request at a time, started by a go pulse
`default_nettype none
// ****************
// ec master model
// ****************
module apm_ec_model
	import apm_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  go_in,
	input  wire logic                  wr_in,
	input  wire logic [apm_pkg::IW-1:0] idx_in,
	input  wire logic [apm_pkg::BW-1:0] data_in,
	input  wire apm_pkg::apm_av_rsp_t  rsp_in,
	output var  apm_pkg::apm_av_req_t  req_out,
	output var  logic                  done_out,
	output var  logic [apm_pkg::BW-1:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic busy = req_out.read || req_out.write;
	always_ff @(posedge clk_in)
	begin
		done_out <= 1'h0;
		if (rst_in)
			req_out <= '0;
		else if (busy && !rsp_in.waitrequest)
		begin
			req_out <= '{1'h0, 1'h0, ~req_out.address, ~req_out.writedata, 4'hf};
			rdata_out <= rsp_in.readdata[BW-1:0];
			done_out <= 1'h1;
		end
		else if (go_in && !busy)
			req_out <= '{!wr_in, wr_in, {idx_in, 2'h0}, {PAD_ZERO, data_in}, 4'hf};
	end
endmodule
`default_nettype wire

/* verif/apm_block_test.sv */
// apm_block_test: self-checking bench of the pm event block
// assumes: design, ec model and bound checker compiled first
`default_nettype none
// ****************
// bench
// ****************
module apm_block_test;
	timeunit 1ns;
	timeprecision 1ps;
	import apm_pkg::*;
	logic          clk_in, rst_in, ce_in, sleep_req_in, go, done, sci_n, ack, sen;
	logic          cirq, eirq, sirq;
	logic [12:0]   gcmd;
	logic [BW-1:0] erd, q, s, e, c, m;
	logic [2:0]    typ;
	apm_av_req_t   hreq, ereq;
	apm_av_rsp_t   hrsp, ersp;
	int            bad_count, samples_checked, cyc;

	apm_block i_apm_block (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.sleep_req_in(sleep_req_in), .host_req_in(hreq), .host_rsp_out(hrsp), .ec_req_in(ereq),
		.ec_rsp_out(ersp), .sleep_ack_out(ack), .sci_out_n(sci_n),
		.control_write_irq_out(cirq), .enable_write_irq_out(eirq),
		.status_write_irq_out(sirq), .sleep_type_field_out(typ),
		.sleep_enable_bit_out(sen));
	apm_ec_model i_apm_ec_model (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
		.wr_in(gcmd[12]), .idx_in(gcmd[11:8]), .data_in(gcmd[7:0]), .rsp_in(ersp),
		.req_out(ereq), .done_out(done), .rdata_out(erd));

	initial
	begin
		clk_in = 1'h0;
		forever #2 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc > 8000)
		begin
			bad_count++;
			summarize();
		end
	end

	function automatic logic exp_sci(logic [BW-1:0] st, logic [BW-1:0] en, logic [BW-1:0] ct);
		return !(|(st[2:0] & en[2:0]) || (st[STS_OVR] && ct[CTL2_OVR_EN]));
	endfunction

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic hop(logic w, logic [IW-1:0] i, logic [BW-1:0] d, logic [3:0] be);
		@(posedge clk_in);
		hreq <= '{!w, w, {i, 2'h0}, {PAD_ZERO, d}, be};
		@(posedge clk_in);
		while (hrsp.waitrequest !== 1'h0)
			@(posedge clk_in);
		q = hrsp.readdata[BW-1:0];
		hreq <= '{1'h0, 1'h0, ~hreq.address, ~hreq.writedata, be};
	endtask

	task automatic eop(logic w, logic [IW-1:0] i, logic [BW-1:0] d);
		@(posedge clk_in);
		go <= 1'h1;
		gcmd <= {w, i, d};
		@(posedge clk_in);
		go <= 1'h0;
		while (done !== 1'h1)
			@(posedge clk_in);
		q = erd;
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		rst_in = 1'h1;
		ce_in = 1'h1;
		sleep_req_in = 1'h0;
		go = 1'h0;
		gcmd = '0;
		hreq = '0;
		void'($urandom(86));
		repeat (2) @(posedge clk_in);
		rst_in <= 1'h0;
		hop(0, IDX_STS2, 0, 4'hf);
		chk("status reset", q, 0);
		chk("sci idle", sci_n, 1);
		hop(1, 4'h9, 8'hff, 4'hf);
		hop(0, 4'h9, 0, 4'hf);
		chk("unmapped", q, 0);
		hop(1, IDX_EN2, 8'h07, 4'he);
		hop(0, IDX_EN2, 0, 4'hf);
		chk("enable masked", q, 0);
		eop(1, IDX_ECSTS, 8'h01);
		hop(1, IDX_ECSTS, 8'h00, 4'hf);
		chk("ec sci", sci_n, 0);
		eop(1, IDX_ECSTS, 8'h00);
		for (int k = 0; k < 16; k++)
		begin
			s = k ? 8'($urandom) : 8'hff;
			e = k ? 8'($urandom) : 8'hff;
			c = 8'($urandom);
			m = 8'($urandom);
			eop(1, IDX_STS2, s);
			hop(1, IDX_EN2, e, 4'hf);
			@(posedge clk_in);
			chk("enable irq", eirq, 1);
			hop(1, IDX_CTL2, c, 4'hf);
			@(posedge clk_in);
			chk("control irq", cirq, 1);
			eop(1, IDX_EN2, ~e);
			chk("no irq on ec write", eirq, 0);
			eop(0, IDX_EN2, 0);
			chk("enable", q, e & EN_MASK);
			eop(0, IDX_STS2, 0);
			chk("status", q, s & STS_MASK);
			chk("sci", sci_n, exp_sci(s, e, c));
			chk("sleep fields", {sen, typ}, c[5:2]);
			hop(1, IDX_STS2, m, 4'hf);
			@(posedge clk_in);
			chk("status irq", sirq, 1);
			hop(1, IDX_STS2, 8'h00, 4'hf);
			hop(0, IDX_STS2, 0, 4'hf);
			chk("cleared", q, s & ~m & STS_MASK);
			chk("sci cleared", sci_n, exp_sci(s & ~m, e, c));
		end
		sleep_req_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		chk("ack", ack, 1);
		fork
			hop(0, IDX_CTL2, 0, 4'hf);
			begin
				repeat (6) @(posedge clk_in);
				sleep_req_in <= 1'h0;
			end
		join
		chk("ctl2 kept", q, c & CTL2_MASK);
		chk("ack low", ack, 0);
		ce_in <= 1'h0;
		fork
			hop(0, IDX_EN2, 0, 4'hf);
			begin
				repeat (3) @(posedge clk_in);
				chk("frozen wait", hrsp.waitrequest, 1);
				ce_in <= 1'h1;
			end
		join
		chk("enable after freeze", q, e & EN_MASK);
		eop(1, IDX_STS2, 8'h0f);
		rst_in <= 1'h1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'h0;
		hop(0, IDX_STS2, 0, 4'hf);
		chk("status rerst", q, 0);
		chk("sci rerst", sci_n, 1);
		summarize();
	end
endmodule
`default_nettype wire
